/* File: logic/fdcr_selector.sv */
/*
 * Mode, transfer rate, density and drive-output selector.
 * Assumes a 25 MHz clk, synchronous inputs, and a host that uses the
 * plain register port with one-cycle strobes.
 */
`timescale 1ns/1ps
module fdcr_selector (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic polarity_select,
    input wire logic mode_select_pin,
    input wire logic rate_pin_low,
    input wire logic rate_pin_high,
    input wire logic precomp_select_low,
    input wire logic precomp_select_high,
    input wire logic format_select_pin,
    input wire logic clock_b_fast,
    input wire logic clock_b_chained,
    output logic density_out_low,
    output logic density_out_high,
    output logic [3:0] drive_selects,
    output logic [3:0] motor_enables,
    output logic direction_out,
    output logic fault_reset_out,
    output logic head_load_out,
    output logic low_current_out,
    output logic side_out,
    output logic step_out,
    output logic write_gate_out,
    output logic int_out,
    output logic dma_request_out,
    output logic data_bus_oe_n,
    output logic [9:0] rate_kbps,
    output logic fm_mode_out,
    output logic format_out,
    output logic [2:0] precomp_amount,
    output logic [1:0] mode_out,
    output logic rate_unavailable
);
    fdcr_pkg::fdcr_mode_t mode;
    logic [7:0] dor;
    logic [7:0] ctrl;
    logic [7:0] drv;
    logic [1:0] int_rate;
    logic [2:0] int_precomp;
    logic int_format;
    logic [3:0] int_motors;
    logic [1:0] int_unit;
    logic int_unit_en;
    logic [3:0] sel_q;
    logic [3:0] mot_q;
    logic [6:0] drv_q;
    logic [1:0] den_q;
    logic int_q;
    logic cmd_wr;
    logic [2:0] opcode;
    logic [1:0] next_code;
    logic [3:0] next_sel;
    logic [3:0] next_mot;
    logic [2:0] next_precomp;
    logic next_format;
    logic [9:0] map_rate;
    logic [1:0] map_den;
    logic map_uses_b;
    logic [7:0] next_rdata;

    // one-hot drive select, all inactive unless enabled
    function automatic logic [3:0] unit_onehot(input logic [1:0] unit, input logic en);
        unit_onehot = en ? (4'h1 << unit) : 4'h0;
    endfunction

    assign opcode = wdata[7:fdcr_pkg::OP_LSB];
    // commands only mean something while the mode pin is low
    assign cmd_wr = wr_stb && (addr == fdcr_pkg::ADDR_CMD) && !mode_select_pin;

    // operating mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode <= fdcr_pkg::FDCR_MODE_EXT;
        end
        else if (ce)
        begin
            if (mode_select_pin)
            begin
                mode <= fdcr_pkg::FDCR_MODE_REG;
            end
            else if (mode == fdcr_pkg::FDCR_MODE_REG)
            begin
                mode <= fdcr_pkg::FDCR_MODE_EXT;
            end
            else if (cmd_wr && opcode == fdcr_pkg::OP_INT_SETUP)
            begin
                mode <= fdcr_pkg::FDCR_MODE_INT;
            end
            else if (cmd_wr && opcode == fdcr_pkg::OP_GO_EXT)
            begin
                mode <= fdcr_pkg::FDCR_MODE_EXT;
            end
        end
    end

    // settings carried by commands
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_rate <= 2'h0;
            int_precomp <= 3'h0;
            int_format <= 1'b0;
            int_motors <= 4'h0;
            int_unit <= 2'h0;
            int_unit_en <= 1'b0;
        end
        else if (ce && cmd_wr)
        begin
            case (opcode)
                fdcr_pkg::OP_INT_SETUP:
                begin
                    int_rate <= wdata[1:0];
                    int_precomp <= wdata[fdcr_pkg::PL_PRECOMP_LSB +: 3];
                end
                fdcr_pkg::OP_FORMAT: int_format <= wdata[0];
                fdcr_pkg::OP_SPINDLE: int_motors <= wdata[3:0];
                fdcr_pkg::OP_UNIT:
                begin
                    int_unit <= wdata[1:0];
                    int_unit_en <= wdata[fdcr_pkg::PL_UNIT_EN_BIT];
                end
                default:
                begin
                end
            endcase
        end
    end

    // digital output register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dor <= fdcr_pkg::REG_RESET;
        end
        else if (ce && wr_stb && addr == fdcr_pkg::ADDR_DOR)
        begin
            dor <= wdata;
        end
    end

    // control register: rate bits and single-density flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= fdcr_pkg::REG_RESET;
        end
        else if (ce && wr_stb && addr == fdcr_pkg::ADDR_CTRL)
        begin
            ctrl <= wdata;
        end
    end

    // drive control levels in logical sense
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv <= fdcr_pkg::REG_RESET;
        end
        else if (ce && wr_stb && addr == fdcr_pkg::ADDR_DRV)
        begin
            drv <= wdata;
        end
    end

    // sources chosen by mode
    always_comb
    begin
        next_code = {rate_pin_high, rate_pin_low};
        next_sel = unit_onehot(int_unit, int_unit_en);
        next_mot = int_motors;
        next_precomp = {rate_pin_high, precomp_select_high, precomp_select_low};
        next_format = format_select_pin;
        case (mode)
            fdcr_pkg::FDCR_MODE_REG:
            begin
                next_code = ctrl[1:0];
                next_sel = unit_onehot(dor[fdcr_pkg::DOR_SEL_LSB +: 2], dor[fdcr_pkg::DOR_SEL_EN_BIT]);
                next_mot = dor[fdcr_pkg::DOR_MOTOR_LSB +: 4];
            end
            fdcr_pkg::FDCR_MODE_INT:
            begin
                next_code = int_rate;
                next_precomp = int_precomp;
                next_format = int_format;
            end
            default:
            begin
            end
        endcase
    end

    fdcr_rate_map u_map (
        .reg_mode(mode == fdcr_pkg::FDCR_MODE_REG),
        .code(next_code),
        .rate_pin_high(rate_pin_high),
        .clock_b_fast(clock_b_fast),
        .fm(ctrl[fdcr_pkg::CTRL_FM_BIT]),
        .rate_kbps(map_rate),
        .den_code(map_den),
        .uses_clock_b(map_uses_b)
    );

    // rate, density and status outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rate_kbps <= fdcr_pkg::RATE_RESET;
            den_q <= fdcr_pkg::DEN_RESET;
            fm_mode_out <= 1'b0;
            format_out <= 1'b0;
            precomp_amount <= 3'h0;
            mode_out <= 2'h0;
            rate_unavailable <= 1'b0;
        end
        else if (ce)
        begin
            rate_kbps <= map_rate;
            den_q <= map_den;
            fm_mode_out <= ctrl[fdcr_pkg::CTRL_FM_BIT];
            format_out <= next_format;
            precomp_amount <= next_precomp;
            mode_out <= mode;
            // with clock A chained into clock B only 500 and 250 are valid
            rate_unavailable <= clock_b_chained && map_uses_b;
        end
    end

    // drive-side logical levels; reset leaves every one inactive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_q <= 4'h0;
            mot_q <= 4'h0;
            drv_q <= 7'h00;
        end
        else if (ce)
        begin
            sel_q <= next_sel;
            mot_q <= next_mot;
            drv_q <= drv[6:0];
        end
    end

    // pin levels follow the polarity input even while reset holds
    assign drive_selects = sel_q ^ {4{polarity_select}};
    assign motor_enables = mot_q ^ {4{polarity_select}};
    assign direction_out = drv_q[fdcr_pkg::DRV_DIR] ^ polarity_select;
    assign fault_reset_out = drv_q[fdcr_pkg::DRV_FAULT_RESET_OUT] ^ polarity_select;
    assign head_load_out = drv_q[fdcr_pkg::DRV_HEAD_LOAD_OUT] ^ polarity_select;
    assign low_current_out = drv_q[fdcr_pkg::DRV_LCT] ^ polarity_select;
    assign side_out = drv_q[fdcr_pkg::DRV_SIDE] ^ polarity_select;
    assign step_out = drv_q[fdcr_pkg::DRV_STEP] ^ polarity_select;
    assign write_gate_out = drv_q[fdcr_pkg::DRV_WG] ^ polarity_select;
    // table values are active-low, so invert for polarity 0
    assign density_out_low = den_q[0] ^ ~polarity_select;
    assign density_out_high = den_q[1] ^ ~polarity_select;

    // command-done flag; a new command beats a status read clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_q <= 1'b0;
        end
        else if (ce)
        begin
            if (cmd_wr)
            begin
                int_q <= 1'b1;
            end
            else if (rd_stb && addr == fdcr_pkg::ADDR_STAT)
            begin
                int_q <= 1'b0;
            end
        end
    end

    // interrupt and dma request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_out <= 1'b0;
            dma_request_out <= 1'b0;
        end
        else if (ce)
        begin
            int_out <= int_q;
            // no transfer engine here, the request stays idle
            dma_request_out <= 1'b0;
        end
    end

    // read mux
    always_comb
    begin
        next_rdata = 8'h00;
        case (addr)
            fdcr_pkg::ADDR_DOR: next_rdata = dor;
            fdcr_pkg::ADDR_CTRL: next_rdata = ctrl;
            fdcr_pkg::ADDR_DRV: next_rdata = drv;
            fdcr_pkg::ADDR_STAT:
                next_rdata = {precomp_amount, rate_unavailable, format_out, fm_mode_out, mode_out};
            fdcr_pkg::ADDR_SETUP:
                next_rdata = {int_motors, int_unit, next_code};
            default: next_rdata = 8'h00;
        endcase
    end

    // read data stands for the one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= 8'h00;
            data_bus_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            rdata <= rd_stb ? next_rdata : 8'h00;
            data_bus_oe_n <= !rd_stb;
        end
    end
endmodule

/* File: logic/fdcr_pkg.sv */
/*
 * Constants, field layout, register map and types for the floppy rate
 * and mode selector. Assumes a single 25 MHz clock and a plain register port.
 */
package fdcr_pkg;
    typedef enum logic [1:0] {FDCR_MODE_EXT, FDCR_MODE_INT, FDCR_MODE_REG} fdcr_mode_t;

    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_CMD = 3'h0;
    localparam logic [2:0] ADDR_DOR = 3'h1;
    localparam logic [2:0] ADDR_CTRL = 3'h2;
    localparam logic [2:0] ADDR_DRV = 3'h3;
    localparam logic [2:0] ADDR_STAT = 3'h4;
    localparam logic [2:0] ADDR_SETUP = 3'h5;

    localparam logic [2:0] OP_INT_SETUP = 3'h1;
    localparam logic [2:0] OP_GO_EXT = 3'h2;
    localparam logic [2:0] OP_FORMAT = 3'h3;
    localparam logic [2:0] OP_SPINDLE = 3'h4;
    localparam logic [2:0] OP_UNIT = 3'h5;
    localparam int OP_LSB = 5;

    localparam int DOR_SEL_LSB = 0;
    localparam int DOR_SEL_EN_BIT = 2;
    localparam int DOR_MOTOR_LSB = 4;
    localparam int CTRL_FM_BIT = 2;
    localparam int PL_PRECOMP_LSB = 2;
    localparam int PL_UNIT_EN_BIT = 2;

    localparam int DRV_DIR = 0;
    localparam int DRV_FAULT_RESET_OUT = 1;
    localparam int DRV_HEAD_LOAD_OUT = 2;
    localparam int DRV_LCT = 3;
    localparam int DRV_SIDE = 4;
    localparam int DRV_STEP = 5;
    localparam int DRV_WG = 6;

    localparam logic [9:0] RATE_150 = 10'h096;
    localparam logic [9:0] RATE_250 = 10'h0FA;
    localparam logic [9:0] RATE_300 = 10'h12C;
    localparam logic [9:0] RATE_500 = 10'h1F4;
    localparam logic [9:0] RATE_600 = 10'h258;

    localparam logic [1:0] DEN_LOWRATE = 2'h2;
    localparam logic [1:0] DEN_500 = 2'h3;
    localparam logic [1:0] DEN_300 = 2'h0;
    localparam logic [1:0] DEN_RESET = 2'h3;
    localparam logic [9:0] RATE_RESET = 10'h1F4;
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage

/* File: logic/fdcr_rate_map.sv */
/*
 * Rate and density lookup for the selector.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module fdcr_rate_map (
    input wire logic reg_mode,
    input wire logic [1:0] code,
    input wire logic rate_pin_high,
    input wire logic clock_b_fast,
    input wire logic fm,
    output logic [9:0] rate_kbps,
    output logic [1:0] den_code,
    output logic uses_clock_b
);
    logic [1:0] cls;
    logic [9:0] mfm;

    // classes: 0 = 250, 1 = 500, 2 = 150/300, 3 = 300/600
    always_comb
    begin
        cls = code;
        if (reg_mode)
        begin
            case (code)
                2'h0: cls = 2'h1;
                2'h1: cls = rate_pin_high ? 2'h3 : 2'h0;
                2'h2: cls = 2'h0;
                default: cls = 2'h2;
            endcase
        end
        case (cls)
            2'h0: mfm = fdcr_pkg::RATE_250;
            2'h1: mfm = fdcr_pkg::RATE_500;
            2'h2: mfm = clock_b_fast ? fdcr_pkg::RATE_300 : fdcr_pkg::RATE_150;
            default: mfm = clock_b_fast ? fdcr_pkg::RATE_600 : fdcr_pkg::RATE_300;
        endcase
        case (cls)
            2'h1: den_code = fdcr_pkg::DEN_500;
            2'h3: den_code = fdcr_pkg::DEN_300;
            default: den_code = fdcr_pkg::DEN_LOWRATE;
        endcase
        uses_clock_b = cls[1];
        rate_kbps = fm ? {1'b0, mfm[9:1]} : mfm;
    end
endmodule

/* File: dv/fdcr_selector_checker.sv */
/* Port-level assertions for fdcr_selector.
   Assumes ce high whenever the watched pins move, and one clock domain. */
`timescale 1ns/1ps
module fdcr_selector_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic rd_stb,
    input wire logic polarity_select,
    input wire logic mode_select_pin,
    input wire logic rate_pin_high,
    input wire logic precomp_select_low,
    input wire logic precomp_select_high,
    input wire logic format_select_pin,
    input wire logic density_out_low,
    input wire logic density_out_high,
    input wire logic [3:0] drive_selects,
    input wire logic direction_out,
    input wire logic step_out,
    input wire logic write_gate_out,
    input wire logic int_out,
    input wire logic dma_request_out,
    input wire logic data_bus_oe_n,
    input wire logic [9:0] rate_kbps,
    input wire logic fm_mode_out,
    input wire logic format_out,
    input wire logic [2:0] precomp_amount,
    input wire logic [1:0] mode_out
);
    logic [1:0] den;
    logic [1:0] pmask;
    assign den = {density_out_high, density_out_low};
    assign pmask = {2{~polarity_select}};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_dma_idle: assert property (dma_request_out == 1'b0)
        else $error("dma request raised");
    a_read_drive: assert property (ce && rd_stb |=> !data_bus_oe_n)
        else $error("bus not driven after read");
    a_bus_release: assert property (ce && !rd_stb |=> data_bus_oe_n)
        else $error("bus driven without read");
    a_reg_mode_entry: assert property (mode_select_pin |-> ##2 mode_out == 2'h2)
        else $error("register mode not entered");
    a_ext_after_fall: assert property ($fell(mode_select_pin) |-> ##2 mode_out == 2'h0)
        else $error("external mode not entered");
    a_reset_idle: assert property ($rose(rst_n) |-> drive_selects == {4{polarity_select}}
        && direction_out == polarity_select && step_out == polarity_select
        && write_gate_out == polarity_select && !int_out)
        else $error("drive outputs not idle after reset");
    a_den_fast: assert property (!fm_mode_out && rate_kbps == 10'h1F4 |-> den == (2'h3 ^ pmask))
        else $error("density wrong at 500");
    a_den_slow: assert property (!fm_mode_out && (rate_kbps == 10'h0FA || rate_kbps == 10'h096)
        |-> den == (2'h2 ^ pmask))
        else $error("density wrong at low rate");
    a_den_top: assert property (rate_kbps == 10'h258 |-> den == pmask)
        else $error("density wrong at 600");
    a_precomp_pins: assert property (mode_out == 2'h2 && $past(mode_out) == 2'h2 && $past(rst_n)
        |-> precomp_amount == $past({rate_pin_high, precomp_select_high, precomp_select_low}))
        else $error("precomp not from pins");
    a_format_pin: assert property (mode_out != 2'h1 && $past(mode_out) != 2'h1 && $past(rst_n)
        |-> format_out == $past(format_select_pin))
        else $error("format not from pin");
endmodule

/* File: dv/fdcr_drive_model.sv */
/* Drive-side model: reads density and motor lines as a drive does.
   Assumes the polarity strap is shared with the selector. */
`timescale 1ns/1ps
module fdcr_drive_model (
    input wire logic polarity_select,
    input wire logic density_out_low,
    input wire logic density_out_high,
    input wire logic [3:0] motor_enables,
    output logic [1:0] den_active_low,
    output logic [3:0] motors_on
);
    assign den_active_low = {density_out_high, density_out_low} ^ {2{~polarity_select}};
    assign motors_on = motor_enables ^ {4{polarity_select}};
endmodule

/* File: dv/fdcr_selector_tb_top.sv */
/* Self-checking bench for fdcr_selector with a drive model.
   Assumes the checker and drive model are compiled first. */
`timescale 1ns/1ps
module fdcr_selector_tb_top;
    logic clk, rst_n, ce, wr_stb, rd_stb, polarity_select, mode_select_pin, rate_pin_low, rate_pin_high;
    logic precomp_select_low, precomp_select_high, format_select_pin, clock_b_fast, clock_b_chained;
    logic density_out_low, density_out_high, direction_out, fault_reset_out, head_load_out, low_current_out;
    logic side_out, step_out, write_gate_out, int_out, dma_request_out, data_bus_oe_n, fm_mode_out;
    logic format_out, rate_unavailable;
    logic [2:0] addr, precomp_amount;
    logic [7:0] wdata, rdata, rd_val;
    logic [3:0] drive_selects, motor_enables, motors_on;
    logic [9:0] rate_kbps;
    logic [1:0] mode_out, den_active_low, c;
    int n_mismatch = 0;
    int total_checks = 0;
    fdcr_selector uut (.clk, .rst_n, .ce, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .polarity_select,
        .mode_select_pin, .rate_pin_low, .rate_pin_high, .precomp_select_low, .precomp_select_high,
        .format_select_pin, .clock_b_fast, .clock_b_chained, .density_out_low, .density_out_high,
        .drive_selects, .motor_enables, .direction_out, .fault_reset_out, .head_load_out, .low_current_out,
        .side_out, .step_out, .write_gate_out, .int_out, .dma_request_out, .data_bus_oe_n, .rate_kbps,
        .fm_mode_out, .format_out, .precomp_amount, .mode_out, .rate_unavailable);
    fdcr_drive_model drv (.polarity_select, .density_out_low, .density_out_high, .motor_enables,
        .den_active_low, .motors_on);
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wt();
        repeat (3) @(posedge clk);
        #1;
    endtask
    function automatic logic [9:0] rate_of(input logic [1:0] k, input logic f);
        case (k)
            2'h0: return fdcr_pkg::RATE_250;
            2'h1: return fdcr_pkg::RATE_500;
            2'h2: return f ? fdcr_pkg::RATE_300 : fdcr_pkg::RATE_150;
            default: return f ? fdcr_pkg::RATE_600 : fdcr_pkg::RATE_300;
        endcase
    endfunction
    function automatic logic [1:0] den_of(input logic [1:0] k);
        return (k == 2'h3) ? 2'h0 : (k == 2'h1) ? 2'h3 : 2'h2;
    endfunction
    task automatic t_reset();
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk);
            polarity_select <= p[0];
            #1 chk("den", {density_out_high, density_out_low}, 2'h3 ^ {2{~p[0]}});
            chk("drv", {drive_selects, direction_out, write_gate_out}, {6{p[0]}});
            chk("host", {int_out, dma_request_out, data_bus_oe_n}, 3'h1);
            chk("mode", mode_out, 2'h0);
        end
    endtask
    task automatic t_ext();
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            {clock_b_fast, rate_pin_high, rate_pin_low} <= k[2:0];
            clock_b_chained <= k[2];
            polarity_select <= k[0];
            wt();
            chk("rate", rate_kbps, rate_of(k[1:0], k[2]));
            chk("den", den_active_low, den_of(k[1:0]));
            chk("unavail", rate_unavailable, k[2] & k[1]);
        end
    endtask
    task automatic t_reg();
        @(posedge clk);
        mode_select_pin <= 1'b1;
        {clock_b_fast, clock_b_chained} <= 2'h0;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk);
            rate_pin_high <= k[2];
            rate_pin_low <= ~k[2];
            {precomp_select_high, precomp_select_low} <= k[1:0];
            format_select_pin <= k[0];
            wr(fdcr_pkg::ADDR_CTRL, {6'h00, k[1:0]});
            wt();
            c = (k[1:0] == 2'h0) ? 2'h1 : (k[1:0] == 2'h3) ? 2'h2 : (k[1:0] == 2'h1 && k[2]) ? 2'h3 : 2'h0;
            chk("rate", rate_kbps, rate_of(c, 1'b0));
            chk("den", den_active_low, den_of(c));
            chk("pc", {precomp_amount, format_out}, {k[2:0], k[0]});
        end
        wr(fdcr_pkg::ADDR_CTRL, 8'h05);
        wr(fdcr_pkg::ADDR_CMD, 8'h37);
        wr(fdcr_pkg::ADDR_DOR, 8'h56);
        wt();
        chk("fm", {fm_mode_out, rate_kbps}, {1'b1, 10'h096});
        chk("mode", {mode_out, int_out}, {2'h2, 1'b0});
        chk("mot", motors_on, 4'h5);
        chk("sel", drive_selects, 4'h4 ^ {4{polarity_select}});
        rd(3'h7, rd_val);
        chk("unmap", rd_val, 8'h00);
        wr(fdcr_pkg::ADDR_CTRL, 8'h00);
    endtask
    task automatic t_int();
        @(posedge clk);
        mode_select_pin <= 1'b0;
        {rate_pin_high, rate_pin_low, format_select_pin} <= 3'h0;
        wr(fdcr_pkg::ADDR_CMD, 8'h37);
        wr(fdcr_pkg::ADDR_CMD, 8'h8A);
        wr(fdcr_pkg::ADDR_CMD, 8'h61);
        wr(fdcr_pkg::ADDR_CMD, 8'hA5);
        wt();
        chk("mode", mode_out, 2'h1);
        chk("rate", {rate_kbps, precomp_amount}, {fdcr_pkg::RATE_300, 3'h5});
        chk("fmt", {format_out, motors_on, int_out}, 6'h35);
        rd(fdcr_pkg::ADDR_SETUP, rd_val);
        chk("setup", rd_val, 8'hA7);
        rd(fdcr_pkg::ADDR_STAT, rd_val);
        chk("stat", rd_val, 8'hA9);
        wt();
        chk("int", int_out, 1'b0);
        wr(fdcr_pkg::ADDR_CMD, 8'h40);
        wr(fdcr_pkg::ADDR_DRV, 8'h7F);
        wt();
        chk("ext", {mode_out, rate_kbps}, {2'h0, fdcr_pkg::RATE_250});
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk);
            polarity_select <= p[0];
            #1 chk("lvl", {direction_out, fault_reset_out, head_load_out, low_current_out, side_out,
                step_out, write_gate_out}, {7{~p[0]}});
        end
    endtask
    task automatic t_hold();
        @(posedge clk);
        ce <= 1'b0;
        wr(fdcr_pkg::ADDR_DRV, 8'h00);
        wr(fdcr_pkg::ADDR_CMD, 8'h20);
        rd(fdcr_pkg::ADDR_STAT, rd_val);
        chk("hold", {rd_val, data_bus_oe_n, int_out, mode_out}, 12'h00C);
        // frozen stretch stands in for the oscillator settle wait before waking
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        wt();
        chk("wake", {mode_out, int_out, direction_out, write_gate_out}, 5'h04);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {rst_n, wr_stb, rd_stb, addr, wdata, polarity_select, mode_select_pin} = '0;
        {rate_pin_low, rate_pin_high, precomp_select_low, precomp_select_high} = '0;
        {format_select_pin, clock_b_fast, clock_b_chained} = '0;
        ce = 1'b1;
        repeat (10) @(posedge clk);
        t_reset();
        rst_n <= 1'b1;
        t_ext();
        t_reg();
        t_int();
        t_hold();
        tally_and_finish();
    end
    initial
    begin
        #(40 * 4000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
bind fdcr_selector fdcr_selector_checker u_chk (.clk, .rst_n, .ce, .rd_stb, .polarity_select,
    .mode_select_pin, .rate_pin_high, .precomp_select_low, .precomp_select_high, .format_select_pin,
    .density_out_low, .density_out_high, .drive_selects, .direction_out, .step_out, .write_gate_out,
    .int_out, .dma_request_out, .data_bus_oe_n, .rate_kbps, .fm_mode_out, .format_out,
    .precomp_amount, .mode_out);
